/* include/cmb_cfg.svh */
// Register offsets, field positions and reset values of the message buffer block
`ifndef CMB_CFG_SVH
`define CMB_CFG_SVH
// Register byte offsets on the Avalon slave
`define CMB_OFF_ERRCNT   5'h00
`define CMB_OFF_RXDATA   5'h04
`define CMB_OFF_TXDATA   5'h08
`define CMB_OFF_CTRL     5'h0C
`define CMB_OFF_IRQ_STS  5'h10
`define CMB_OFF_IRQ_MASK 5'h14
// Reset values
`define CMB_RST_WORD     16'h0000
`define CMB_RST_IRQ      3'h0
// Words per message buffer and last word index
`define CMB_WORDS        8
`define CMB_LAST_IDX     3'h7
// Buffer word 0 fields
`define CMB_W0_SID_LSB   2
`define CMB_W0_SRR_BIT   1
`define CMB_W0_IDE_BIT   0
// Buffer word 1 / word 2 fields
`define CMB_W1_EIDH_LSB  0
`define CMB_W2_EIDL_LSB  10
`define CMB_W2_RTR_BIT   9
`define CMB_W2_DLC_LSB   0
// Buffer word 7 field
`define CMB_W7_HIT_LSB   8
// Control register bits
`define CMB_CTRL_RXEN    0
`define CMB_CTRL_TXGO    1
`define CMB_CTRL_RXBUSY  2
`define CMB_CTRL_TXBUSY  3
// Interrupt status bits
`define CMB_IRQ_RXDONE   0
`define CMB_IRQ_TXDONE   1
`define CMB_IRQ_TXREFUSE 2
`endif

/* include/cmb_pkg.sv */
// Types shared by the message buffer block
package cmb_pkg;
    typedef logic [15:0] cmb_word_t;   // One buffer word
    typedef logic [2:0]  cmb_widx_t;   // Word index 0..7
    // Receive hand-out sequencer
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_STORE = 3'b001,
        RX_FETCH = 3'b010,
        RX_LOAD  = 3'b011,
        RX_WAIT  = 3'b100
    } cmb_rx_state_t;
    // Transmit collection sequencer
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_REQ  = 2'b01,
        TX_WAIT = 2'b10
    } cmb_tx_state_t;
endpackage

/* logic/cmb_msg_mem.sv */
// Small message word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_mem #(
    parameter int DW = 16,             // Word width
    parameter int DEPTH = 8,           // Number of words
    parameter int AW = 3               // Address width
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem_r [DEPTH];      // Storage, no reset needed

    // Write port
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_r[waddr] <= wdata;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= mem_r[raddr];
        end
    end
endmodule // cmb_msg_mem
`default_nettype wire

/* logic/cmb_word_pack.sv */
// Builds one buffer word of a received message from its fields
`timescale 1ns/1ps
`default_nettype none
`include "cmb_cfg.svh"
module cmb_word_pack
    import cmb_pkg::*;
(
    input  wire logic [2:0]  idx,
    input  wire logic        ext,
    input  wire logic        remote,
    input  wire logic [10:0] sid,
    input  wire logic [17:0] eid,
    input  wire logic [3:0]  dlc,
    input  wire logic [63:0] payload,
    input  wire logic [4:0]  filter,
    output cmb_word_t        word
);
    logic [2:0] byte_pair;             // Payload word 0..3

    // Word selection; unused and reserved bits are written as zero
    always_comb
    begin
        byte_pair = 3'(idx - 3'h3);
        word = `CMB_RST_WORD;
        unique case (idx)
            3'h0:
            begin
                word[`CMB_W0_SID_LSB +: 11] = sid;
                word[`CMB_W0_SRR_BIT] = ext ? 1'b1 : remote;
                word[`CMB_W0_IDE_BIT] = ext;
            end
            3'h1: word[`CMB_W1_EIDH_LSB +: 12] = eid[17:6];
            3'h2:
            begin
                word[`CMB_W2_EIDL_LSB +: 6] = eid[5:0];
                word[`CMB_W2_RTR_BIT] = ext & remote;
                word[`CMB_W2_DLC_LSB +: 4] = dlc;
            end
            3'h3, 3'h4, 3'h5, 3'h6:
                word = payload[16*byte_pair[1:0] +: 16];
            3'h7: word[`CMB_W7_HIT_LSB +: 5] = filter;
        endcase
    end
endmodule // cmb_word_pack
`default_nettype wire

/* logic/cmb_msgbuf.sv */
// Message buffer word engine with data registers and Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "cmb_cfg.svh"
module cmb_msgbuf
    import cmb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // Error counters from the protocol engine
    input  wire logic [7:0]  transmit_error_counter,
    input  wire logic [7:0]  receive_error_counter,
    // Received message from the protocol engine
    input  wire logic        rx_msg_valid,
    output logic             rx_msg_ready,
    input  wire logic        rx_ext,
    input  wire logic        rx_remote,
    input  wire logic [10:0] rx_std_id,
    input  wire logic [17:0] rx_ext_id,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [63:0] rx_payload,
    input  wire logic [4:0]  matched_filter_number,
    // Transfer requests to the DMA controller
    output logic             rx_dma_req,
    output logic             tx_dma_req,
    // Message to the protocol engine
    output logic             tx_msg_valid,
    output logic             extended_id_select,
    output logic             tx_remote,
    output logic      [10:0] tx_std_id,
    output logic      [17:0] tx_ext_id,
    output logic      [3:0]  tx_dlc,
    output logic      [63:0] tx_payload
);
    // Byte-enable merge of a 16-bit register
    function automatic cmb_word_t be_merge(input cmb_word_t old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
        cmb_word_t res;
        res = old_v;
        if (be[0]) res[7:0] = new_v[7:0];
        if (be[1]) res[15:8] = new_v[15:8];
        return res;
    endfunction

    cmb_rx_state_t rx_state_r;         // Receive sequencer
    cmb_tx_state_t tx_state_r;         // Transmit sequencer
    cmb_widx_t     rx_idx_r;           // Receive word index
    cmb_widx_t     tx_idx_r;           // Transmit word index
    cmb_word_t     rx_word_r;          // Receive data word register
    cmb_word_t     tx_word_r;          // Transmit data word register
    cmb_word_t     pack_word;          // Packed word for rx_idx_r
    cmb_word_t     mem_rdata;          // Stored word read back
    logic          rx_en_r;            // Receive hand-out enabled
    logic [2:0]    irq_sts_r;          // Sticky event bits
    logic [2:0]    irq_mask_r;         // Event enables
    logic [2:0]    irq_set;            // Events this cycle
    logic          w0_srr_r;           // Word 0 remote bit seen
    logic          w2_rtr_r;           // Word 2 remote bit seen
    // Latched received message, held while it is packed
    logic          rxl_ext_r;
    logic          rxl_remote_r;
    logic [10:0]   rxl_sid_r;
    logic [17:0]   rxl_eid_r;
    logic [3:0]    rxl_dlc_r;
    logic [63:0]   rxl_payload_r;
    logic [4:0]    rxl_filter_r;
    // Bus strobes
    logic          acc;                // Access completes this edge
    logic          wr_acc;
    logic          rd_rx_acc;          // Receive word taken by the bus
    logic          wr_tx_acc;          // Transmit word given by the bus
    logic          tx_go;              // Software starts a collection
    logic          mem_we;

    assign acc       = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr_acc    = acc & avs_write;
    assign rd_rx_acc = acc & avs_read & (avs_address == `CMB_OFF_RXDATA);
    assign wr_tx_acc = wr_acc & (avs_address == `CMB_OFF_TXDATA);
    assign tx_go     = wr_acc & (avs_address == `CMB_OFF_CTRL)
                     & avs_byteenable[0] & avs_writedata[`CMB_CTRL_TXGO];
    assign mem_we    = (rx_state_r == RX_STORE);

    // Packs the latched message one word at a time
    cmb_word_pack u_pack (
        .idx     (rx_idx_r),
        .ext     (rxl_ext_r),
        .remote  (rxl_remote_r),
        .sid     (rxl_sid_r),
        .eid     (rxl_eid_r),
        .dlc     (rxl_dlc_r),
        .payload (rxl_payload_r),
        .filter  (rxl_filter_r),
        .word    (pack_word)
    );

    // Receive message buffer image
    cmb_msg_mem #(
        .DW    (16),
        .DEPTH (`CMB_WORDS),
        .AW    (3)
    ) u_rx_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (mem_we),
        .waddr (rx_idx_r),
        .wdata (pack_word),
        .raddr (rx_idx_r),
        .rdata (mem_rdata)
    );

    // Wait state: one wait cycle per access so read data can be registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end

    // Read data mux, captured in the first cycle of a read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= '0;
        else if (avs_read & avs_waitrequest)
        begin
            avs_readdata <= '0;        // Unmapped reads return zero
            unique case (avs_address)
                `CMB_OFF_ERRCNT:
                    avs_readdata[15:0] <= {transmit_error_counter,
                                           receive_error_counter};
                `CMB_OFF_RXDATA:   avs_readdata[15:0] <= rx_word_r;
                `CMB_OFF_TXDATA:   avs_readdata[15:0] <= tx_word_r;
                `CMB_OFF_CTRL:
                    avs_readdata[3:0] <= {tx_state_r != TX_IDLE,
                                          rx_state_r != RX_IDLE,
                                          1'b0, rx_en_r};
                `CMB_OFF_IRQ_STS:  avs_readdata[2:0] <= irq_sts_r;
                `CMB_OFF_IRQ_MASK: avs_readdata[2:0] <= irq_mask_r;
                default:           avs_readdata <= '0;
            endcase
        end
    end

    // Receive enable bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_en_r <= 1'b0;
        else if (wr_acc & (avs_address == `CMB_OFF_CTRL) & avs_byteenable[0])
            rx_en_r <= avs_writedata[`CMB_CTRL_RXEN];
    end

    // Latch an accepted message so the engine may move on at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxl_ext_r     <= 1'b0;
            rxl_remote_r  <= 1'b0;
            rxl_sid_r     <= '0;
            rxl_eid_r     <= '0;
            rxl_dlc_r     <= '0;
            rxl_payload_r <= '0;
            rxl_filter_r  <= '0;
        end
        else if (rx_msg_valid & rx_msg_ready)
        begin
            rxl_ext_r     <= rx_ext;
            rxl_remote_r  <= rx_remote;
            rxl_sid_r     <= rx_std_id;
            rxl_eid_r     <= rx_ext_id;
            rxl_dlc_r     <= rx_dlc;
            rxl_payload_r <= rx_payload;
            rxl_filter_r  <= matched_filter_number;
        end
    end

    // Receive sequencer: store eight words, then hand them out in order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state_r   <= RX_IDLE;
            rx_idx_r     <= '0;
            rx_msg_ready <= 1'b0;
            rx_dma_req   <= 1'b0;
        end
        else
        begin
            rx_dma_req <= 1'b0;
            unique case (rx_state_r)
                RX_IDLE:
                begin
                    // Ready only when enabled, so disabled holds off the engine
                    rx_msg_ready <= rx_en_r & ~(rx_msg_valid & rx_msg_ready);
                    rx_idx_r     <= '0;
                    if (rx_msg_valid & rx_msg_ready)
                        rx_state_r <= RX_STORE;
                end
                RX_STORE:
                begin
                    rx_idx_r <= 3'(rx_idx_r + 3'h1);
                    if (rx_idx_r == `CMB_LAST_IDX)
                        rx_state_r <= RX_FETCH;
                end
                RX_FETCH: rx_state_r <= RX_LOAD;   // Memory read latency
                RX_LOAD:
                begin
                    rx_dma_req <= 1'b1;
                    rx_state_r <= RX_WAIT;
                end
                RX_WAIT:
                begin
                    if (rd_rx_acc)
                    begin
                        rx_idx_r <= 3'(rx_idx_r + 3'h1);
                        rx_state_r <= (rx_idx_r == `CMB_LAST_IDX)
                                      ? RX_IDLE : RX_FETCH;
                    end
                end
                default: rx_state_r <= RX_IDLE;   // Illegal codes recover
            endcase
        end
    end

    // Receive data word: hardware load wins over a software write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_word_r <= `CMB_RST_WORD;
        else if (rx_state_r == RX_LOAD)
            rx_word_r <= mem_rdata;
        else if (wr_acc & (avs_address == `CMB_OFF_RXDATA))
            rx_word_r <= be_merge(rx_word_r, avs_writedata, avs_byteenable);
    end

    // Transmit data word register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_word_r <= `CMB_RST_WORD;
        else if (wr_tx_acc)
            tx_word_r <= be_merge(tx_word_r, avs_writedata, avs_byteenable);
    end

    // Transmit sequencer: request each word, collect it, then hand off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state_r   <= TX_IDLE;
            tx_idx_r     <= '0;
            tx_dma_req   <= 1'b0;
            tx_msg_valid <= 1'b0;
        end
        else
        begin
            tx_dma_req   <= 1'b0;
            tx_msg_valid <= 1'b0;
            unique case (tx_state_r)
                TX_IDLE:
                begin
                    tx_idx_r <= '0;
                    if (tx_go)
                        tx_state_r <= TX_REQ;
                end
                TX_REQ:
                begin
                    tx_dma_req <= 1'b1;
                    tx_state_r <= TX_WAIT;
                end
                TX_WAIT:
                begin
                    if (wr_tx_acc)
                    begin
                        tx_idx_r <= 3'(tx_idx_r + 3'h1);
                        if (tx_idx_r == `CMB_LAST_IDX)
                        begin
                            tx_msg_valid <= 1'b1;
                            tx_state_r   <= TX_IDLE;
                        end
                        else
                            tx_state_r <= TX_REQ;
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // Unpack each written word into the outgoing message fields
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extended_id_select <= 1'b0;
            tx_remote          <= 1'b0;
            tx_std_id          <= '0;
            tx_ext_id          <= '0;
            tx_dlc             <= '0;
            tx_payload         <= '0;
            w0_srr_r           <= 1'b0;
            w2_rtr_r           <= 1'b0;
        end
        else if (tx_state_r == TX_WAIT && wr_tx_acc)
        begin
            // Reserved and unused bits of the written word are not used
            unique case (tx_idx_r)
                3'h0:
                begin
                    tx_std_id <= avs_writedata[`CMB_W0_SID_LSB +: 11];
                    w0_srr_r  <= avs_writedata[`CMB_W0_SRR_BIT];
                    extended_id_select <= avs_writedata[`CMB_W0_IDE_BIT];
                end
                3'h1: tx_ext_id[17:6] <= avs_writedata[11:0];
                3'h2:
                begin
                    tx_ext_id[5:0] <= avs_writedata[`CMB_W2_EIDL_LSB +: 6];
                    w2_rtr_r <= avs_writedata[`CMB_W2_RTR_BIT];
                    tx_dlc   <= avs_writedata[`CMB_W2_DLC_LSB +: 4];
                end
                3'h3, 3'h4, 3'h5, 3'h6:
                    // Word 3 is payload slot 0; the cast keeps the slot 2 bits
                    tx_payload[16*2'(tx_idx_r - 3'h3) +: 16]
                        <= avs_writedata[15:0];
                3'h7:
                    // Word 7 has no meaning for transmit; remote is resolved
                    tx_remote <= extended_id_select ? w2_rtr_r
                                                    : w0_srr_r;
            endcase
        end
    end

    // Events for the interrupt status
    always_comb
    begin
        irq_set = '0;
        irq_set[`CMB_IRQ_RXDONE]   = (rx_state_r == RX_WAIT) & rd_rx_acc
                                   & (rx_idx_r == `CMB_LAST_IDX);
        irq_set[`CMB_IRQ_TXDONE]   = (tx_state_r == TX_WAIT) & wr_tx_acc
                                   & (tx_idx_r == `CMB_LAST_IDX);
        irq_set[`CMB_IRQ_TXREFUSE] = tx_go & (tx_state_r != TX_IDLE);
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_sts_r <= `CMB_RST_IRQ;
        else if (wr_acc & (avs_address == `CMB_OFF_IRQ_STS) & avs_byteenable[0])
            irq_sts_r <= (irq_sts_r & ~avs_writedata[2:0]) | irq_set;
        else
            irq_sts_r <= irq_sts_r | irq_set;
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask_r <= `CMB_RST_IRQ;
        else if (wr_acc & (avs_address == `CMB_OFF_IRQ_MASK) & avs_byteenable[0])
            irq_mask_r <= avs_writedata[2:0];
    end

    // Level interrupt, registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_sts_r & irq_mask_r);
    end

    // Checks on the design's own behaviour
    AST_ERRCNT_READ: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && avs_waitrequest && avs_address == `CMB_OFF_ERRCNT)
        |=> avs_readdata == {16'h0000, $past(transmit_error_counter),
                             $past(receive_error_counter)})
        else $error("error count read wrong");
    AST_RXWORD_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        rx_dma_req |-> rx_word_r == mem_rdata)
        else $error("receive word not loaded before request");
    AST_TXWORD_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_tx_acc && avs_byteenable[1:0] == 2'h3)
        |=> tx_word_r == $past(avs_writedata[15:0]))
        else $error("transmit word not stored");
    AST_W0_LAYOUT: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_we && rx_idx_r == 3'h0) |-> pack_word[15:13] == 3'h0
        && pack_word[12:2] == rxl_sid_r && pack_word[0] == rxl_ext_r)
        else $error("word 0 layout wrong");
    AST_W2_LAYOUT: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_we && rx_idx_r == 3'h2) |-> pack_word[3:0] == rxl_dlc_r
        && pack_word[8:4] == 5'h00 && pack_word[15:10] == rxl_eid_r[5:0])
        else $error("word 2 layout wrong");
    AST_W7_HIT: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_we && rx_idx_r == 3'h7)
        |-> pack_word == {3'h0, rxl_filter_r, 8'h00})
        else $error("filter hit word wrong");
    AST_RX_ONE_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        rx_dma_req |=> !rx_dma_req [*3])
        else $error("receive request repeated");
    AST_TX_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        tx_msg_valid |-> $past(tx_idx_r) == 3'h7 && tx_idx_r == 3'h0)
        else $error("transmit message short");
    AST_TX_REMOTE: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_msg_valid && !extended_id_select) |-> tx_remote == w0_srr_r)
        else $error("standard remote bit ignored");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        |(irq_sts_r & irq_mask_r) |=> irq)
        else $error("interrupt not raised");
endmodule // cmb_msgbuf
`default_nettype wire

/* tb/cmb_dma_model.sv */
// DMA controller model that moves message words over the register bus
`timescale 1ns/1ps
`default_nettype none
module cmb_dma_model (
    input  wire logic        clk,
    input  wire logic        rx_dma_req,
    input  wire logic        tx_dma_req,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata
);
    logic [15:0] rxq[$];  // Words fetched into buffer memory
    logic [15:0] txq[$];  // Message held in buffer memory
    logic [31:0] rd;      // Data of the last read
    initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0000, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // One word moved per request, so word order follows the requests
    always @(posedge clk)
        if (rx_dma_req === 1'b1)
        begin
            bus(1'b0, 5'h04, 16'h0000, rd);
            rxq.push_back(rd[15:0]);
        end
        else if (tx_dma_req === 1'b1)
            bus(1'b1, 5'h08, txq.pop_front(), rd);
endmodule // cmb_dma_model
`default_nettype wire

/* tb/cmb_msgbuf_tb.sv */
// Bench for the message buffer block against a DMA model
`timescale 1ns/1ps
`default_nettype none
module cmb_msgbuf_tb;
    logic clk = 0, rst_n = 0, rx_msg_valid = 0, rx_ext = 0, rx_remote = 0;
    logic [3:0] avs_byteenable = 4'h3, rx_dlc = '0, tx_dlc;
    logic [7:0] transmit_error_counter = '0, receive_error_counter = '0;
    logic [10:0] rx_std_id = '0, tx_std_id;
    logic [17:0] rx_ext_id = '0, tx_ext_id;
    logic [63:0] rx_payload = '0, tx_payload;
    logic [4:0] matched_filter_number = '0, avs_address;
    logic [31:0] avs_readdata, avs_writedata, r;
    logic avs_read, avs_write, avs_waitrequest, irq, rx_msg_ready, tx_remote;
    logic rx_dma_req, tx_dma_req, tx_msg_valid, extended_id_select;
    int n_mismatch = 0, compares = 0, n;
    wire [98:0] got = {extended_id_select, tx_remote, tx_std_id, tx_ext_id,
                       tx_dlc, tx_payload};
    wire [98:0] exp = {rx_ext, rx_remote, rx_std_id, rx_ext_id, rx_dlc,
                       rx_payload};
    cmb_msgbuf DUT (.*);
    cmb_dma_model M (.*);
    always #10 clk = ~clk;
    task chk(input logic [98:0] g, e);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rw(input logic w, input logic [4:0] a, input logic [15:0] d);
        M.bus(w, a, d, r);
    endtask
    // New random message; reserved bits stay zero in the words
    task rnd(input int k);
        rx_ext <= k[0];
        {rx_remote, rx_std_id, rx_ext_id, rx_dlc, matched_filter_number}
            <= 39'({$urandom, $urandom});
        rx_payload <= {$urandom, $urandom};
        {transmit_error_counter, receive_error_counter} <= 16'($urandom);
    endtask
    // Expected buffer word, extended frames always set word 0 bit 1
    function automatic logic [15:0] ew(input int i);
        case (i)
            0: return {3'h0, rx_std_id, rx_ext | rx_remote, rx_ext};
            1: return {4'h0, rx_ext_id[17:6]};
            2: return {rx_ext_id[5:0], rx_ext & rx_remote, 5'h00, rx_dlc};
            7: return {3'h0, matched_filter_number, 8'h00};
            default: return rx_payload[(i - 3) * 16 +: 16];
        endcase
    endfunction
    task conclude;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #1ms;
        n_mismatch++;
        conclude;
    end
    initial
    begin
        void'($urandom(79));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rnd(0);
        rw(1'b1, 5'h00, 16'hFFFF);
        rw(1'b0, 5'h00, 16'h0000);
        chk(r, {transmit_error_counter, receive_error_counter});
        for (int a = 4; a <= 8; a += 4)
        begin
            rw(1'b0, 5'(a), 16'h0000);
            chk(r, '0);
            rw(1'b1, 5'(a), rx_payload[15:0]);
            rw(1'b0, 5'(a), 16'h0000);
            chk(r, rx_payload[15:0]);
        end
        rw(1'b0, 5'h1C, 16'h0000);
        chk(r, '0);
        for (int k = 0; k < 2; k++)
        begin
            rw(1'b1, 5'h14, 16'h0007);
            rw(1'b1, 5'h0C, 16'h0001);
            rnd(k);
            rx_msg_valid <= 1'b1;
            n = 0;
            do @(posedge clk); while (rx_msg_ready !== 1'b1 && ++n < 300);
            rx_msg_valid <= 1'b0;
            n = 0;
            do @(posedge clk); while (M.rxq.size() < 8 && ++n < 300);
            if (n >= 300) n_mismatch++;
            for (int i = 0; i < 8; i++)
                chk(M.rxq.pop_front(), ew(i));
            repeat (3) @(posedge clk);
            chk(irq, 1'b1);
            rw(1'b0, 5'h10, 16'h0000);
            chk(r, 32'h1);
            rw(1'b1, 5'h10, 16'h0001);
            rw(1'b1, 5'h14, 16'h0000);
            for (int i = 0; i < 8; i++)
                M.txq.push_back(ew(i));
            rw(1'b1, 5'h0C, 16'h0002);
            n = 0;
            do @(posedge clk); while (tx_msg_valid !== 1'b1 && ++n < 300);
            if (n >= 300) n_mismatch++;
            chk(got, exp);
            rw(1'b0, 5'h10, 16'h0000);
            chk({irq, r}, 33'h2);
            rw(1'b1, 5'h10, 16'h0002);
        end
        conclude;
    end
endmodule // cmb_msgbuf_tb
`default_nettype wire
